// *** ssce_exec.v ***
/*
 Decode and execute stage for the store, shift, set-on-less-than,
 subtract and software debug trap instructions.
 Assumes the pipeline presents one instruction with its operands per
 valid cycle and that other instructions are handled elsewhere.
*/
`timescale 1ns/10ps
`include "ssce_map.vh"
// Notes on behaviour
// - Special function 001110 raises debug trap; bits 25..6 hold code.
// - Trap code is not output; handler reads instruction via debug PC.
// - Half store writes low target halfword at base plus signed offset.
// - Half store with odd address raises address error, no write.
// - Immediate left shift by shift field, zero fill, to destination.
// - Variable left shift by low five source bits, zero fill.
// - Immediate logical right shift by shift field, zero fill.
// - Variable logical right shift by low five source bits.
// - Immediate arithmetic right shift replicates sign bit.
// - Variable arithmetic right shift replicates sign bit.
// - Signed register compare writes one when source below target.
// - Unsigned register compare writes one when source below target.
// - Signed immediate compare against sign-extended immediate.
// - Unsigned immediate compare uses sign-extended immediate, unsigned.
// - Compares never overflow and stay correct on overflowed difference.
// - Trapping subtract raises overflow and leaves destination alone.
// - Non-trapping subtract always writes, never traps.
// - Word store needs low address bits 00, else address error.
// - Left partial store writes register MSB down to word's low byte.
// - Left partial store touches one word, one to four bytes, no error.
// - Right partial store writes register LSB up to word's high byte.
module ssce_exec (
   // Clock and control.
   input  wire        clock,
   input  wire        rst,
   input  wire        clockEnable,
   input  wire        bigEndian,
   // Instruction and operands.
   input  wire        instrValid,
   input  wire [31:0] instrWord,
   input  wire [31:0] sourceValue,
   input  wire [31:0] targetValue,
   // Register writeback.
   output reg         wbEnable,
   output reg  [4:0]  wbIndex,
   output reg  [31:0] wbData,
   // Store port.
   output reg         storeValid,
   output reg  [31:0] storeAddr,
   output reg  [3:0]  storeByteEnable,
   output reg  [31:0] storeData,
   // Exception report.
   output reg         excValid,
   output reg  [1:0]  excCode,
   output reg  [31:0] excBadAddr
);
   wire [5:0]  opcode;
   wire [5:0]  funct;
   wire [4:0]  shiftField;
   wire [4:0]  sourceIdx;
   wire [4:0]  targetIdx;
   wire [4:0]  destIdx;
   wire [31:0] immExt;
   wire [31:0] effAddr;
   wire        isSpecial;
   wire [31:0] aluResult;
   wire        aluOverflow;
   wire [3:0]  laneEnable;
   wire [31:0] laneData;

   reg  [2:0]  aluSel;
   reg  [4:0]  aluShift;
   reg  [31:0] aluA;
   reg  [31:0] aluB;
   reg         aluWrite;
   reg  [4:0]  aluDest;
   reg         subTrap;
   reg         isStore;
   reg  [1:0]  storeSize;
   reg         debugTrap;

   reg         next_wbEnable;
   reg         next_storeValid;
   reg         next_excValid;
   reg  [1:0]  next_excCode;

   // Field extraction shared by every format.
   assign opcode     = instrWord[`SSCE_OP_HI:`SSCE_OP_LO];
   assign funct      = instrWord[`SSCE_FN_HI:`SSCE_FN_LO];
   assign shiftField = instrWord[`SSCE_SHAMT_HI:`SSCE_SHAMT_LO];
   assign sourceIdx  = instrWord[`SSCE_SRC_HI:`SSCE_SRC_LO];
   assign targetIdx  = instrWord[`SSCE_TGT_HI:`SSCE_TGT_LO];
   assign destIdx    = instrWord[`SSCE_DST_HI:`SSCE_DST_LO];
   assign isSpecial  = opcode == `SSCE_OP_SPECIAL;
   // signed offset address. Same sum serves every store.
   assign immExt     = {{16{instrWord[15]}}, instrWord[15:0]};
   assign effAddr    = sourceValue + immExt;

   // Decode into ALU controls, store controls and trap request.
   always @* begin
      aluSel    = 3'h7;
      aluShift  = shiftField;
      aluA      = sourceValue;
      aluB      = targetValue;
      aluWrite  = 1'b0;
      aluDest   = destIdx;
      subTrap   = 1'b0;
      isStore   = 1'b0;
      storeSize = `SSCE_SIZE_WORD;
      debugTrap = 1'b0;
      if (isSpecial) begin
         case (funct)
            `SSCE_FN_SLI: begin
               aluSel   = 3'h0;
               aluWrite = 1'b1;
            end
            `SSCE_FN_SLV: begin
               aluSel   = 3'h0;
               aluShift = sourceValue[4:0];
               aluWrite = 1'b1;
            end
            `SSCE_FN_SRLI: begin
               aluSel   = 3'h1;
               aluWrite = 1'b1;
            end
            `SSCE_FN_SHIFT_RIGHT_LOGIC_VAR: begin
               aluSel   = 3'h1;
               aluShift = sourceValue[4:0];
               aluWrite = 1'b1;
            end
            `SSCE_FN_SRAI: begin
               aluSel   = 3'h2;
               aluWrite = 1'b1;
            end
            `SSCE_FN_SHIFT_RIGHT_ARITH_VAR: begin
               aluSel   = 3'h2;
               aluShift = sourceValue[4:0];
               aluWrite = 1'b1;
            end
            `SSCE_FN_LTS: begin
               aluSel   = 3'h3;
               aluWrite = 1'b1;
            end
            `SSCE_FN_LTU: begin
               aluSel   = 3'h4;
               aluWrite = 1'b1;
            end
            `SSCE_FN_SUBT: begin
               aluSel   = 3'h5;
               aluWrite = 1'b1;
               subTrap  = 1'b1;
            end
            `SSCE_FN_SUBN: begin
               aluSel   = 3'h5;
               aluWrite = 1'b1;
            end
            `SSCE_FN_DBGTRAP: debugTrap = 1'b1;
            default: aluSel = 3'h7;
         endcase
      end else begin
         case (opcode)
            `SSCE_OP_LTSI: begin
               aluSel   = 3'h3;
               aluB     = immExt;
               aluWrite = 1'b1;
               aluDest  = targetIdx;
            end
            `SSCE_OP_LTUI: begin
               aluSel   = 3'h4;
               aluB     = immExt;
               aluWrite = 1'b1;
               aluDest  = targetIdx;
            end
            `SSCE_OP_STHALF: begin
               isStore   = 1'b1;
               storeSize = `SSCE_SIZE_HALF;
            end
            `SSCE_OP_STWORD:   isStore = 1'b1;
            `SSCE_OP_STPLEFT: begin
               isStore   = 1'b1;
               storeSize = `SSCE_SIZE_LEFT;
            end
            `SSCE_OP_STPRIGHT: begin
               isStore   = 1'b1;
               storeSize = `SSCE_SIZE_RIGHT;
            end
            default: isStore = 1'b0;
         endcase
      end
   end

   // compares never trap. Only the trapping subtract looks at
   // the ALU overflow flag.
   ssce_alu #(
      .WIDTH       (32)
   ) u_alu (
      .opSel       (aluSel),
      .shiftAmount (aluShift),
      .opA         (aluA),
      .opB         (aluB),
      .result      (aluResult),
      .overflow    (aluOverflow)
   );

   // lane steering. Byte enables follow address and order.
   ssce_store_lane u_lane (
      .storeSize   (storeSize),
      .addrLow     (effAddr[1:0]),
      .bigEndian   (bigEndian),
      .regData     (targetValue),
      .byteEnable  (laneEnable),
      .laneData    (laneData)
   );

   // Exception priority and write suppression for this instruction.
   always @* begin
      next_wbEnable   = 1'b0;
      next_storeValid = 1'b0;
      next_excValid   = 1'b0;
      next_excCode    = `SSCE_EXC_NONE;
      if (instrValid) begin
         if (debugTrap) begin
            // code not delivered. Only the trap kind is
            // reported; the handler fetches the word itself.
            next_excValid = 1'b1;
            next_excCode  = `SSCE_EXC_DEBUG;
         end else if (subTrap && aluOverflow) begin
            next_excValid = 1'b1;
            next_excCode  = `SSCE_EXC_OVF;
         end else if (isStore && storeSize == `SSCE_SIZE_HALF &&
                      effAddr[0]) begin
            next_excValid = 1'b1;
            next_excCode  = `SSCE_EXC_ADDR;
         end else if (isStore && storeSize == `SSCE_SIZE_WORD &&
                      effAddr[1:0] != 2'h0) begin
            next_excValid = 1'b1;
            next_excCode  = `SSCE_EXC_ADDR;
         end else begin
            // partial stores pass unaligned. One word only.
            next_storeValid = isStore;
            next_wbEnable   = aluWrite;
         end
      end
   end

   // Result registers; all outputs are flops so the next stage sees
   // clean timing, at the cost of one cycle of latency.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wbEnable        <= 1'b0;
         wbIndex         <= 5'h00;
         wbData          <= 32'h00000000;
         storeValid      <= 1'b0;
         storeAddr       <= 32'h00000000;
         storeByteEnable <= 4'h0;
         storeData       <= 32'h00000000;
         excValid        <= 1'b0;
         excCode         <= `SSCE_EXC_NONE;
         excBadAddr      <= 32'h00000000;
      end else if (clockEnable) begin
         wbEnable        <= next_wbEnable;
         wbIndex         <= aluDest;
         wbData          <= aluResult;
         storeValid      <= next_storeValid;
         // Word address: the lane enables select bytes within it.
         storeAddr       <= {effAddr[31:2], 2'h0};
         storeByteEnable <= next_storeValid ? laneEnable : 4'h0;
         storeData       <= laneData;
         excValid        <= next_excValid;
         excCode         <= next_excCode;
         excBadAddr      <= effAddr;
      end
   end
endmodule // ssce_exec

// *** ssce_map.vh ***
/*
 Constants for the store, shift, compare and subtract execute slice:
 instruction field positions, opcode and function codes.
 Assumes a 32-bit instruction word in the usual three-format layout.
*/
`ifndef SSCE_MAP_VH
`define SSCE_MAP_VH
`define SSCE_OP_HI        31
`define SSCE_OP_LO        26
`define SSCE_SRC_HI       25
`define SSCE_SRC_LO       21
`define SSCE_TGT_HI       20
`define SSCE_TGT_LO       16
`define SSCE_DST_HI       15
`define SSCE_DST_LO       11
`define SSCE_SHAMT_HI     10
`define SSCE_SHAMT_LO     6
`define SSCE_FN_HI        5
`define SSCE_FN_LO        0
`define SSCE_CODE_HI      25
`define SSCE_CODE_LO      6
`define SSCE_OP_SPECIAL   6'h00
`define SSCE_OP_LTSI      6'h0A
`define SSCE_OP_LTUI      6'h0B
`define SSCE_OP_STHALF    6'h29
`define SSCE_OP_STPLEFT   6'h2A
`define SSCE_OP_STWORD    6'h2B
`define SSCE_OP_STPRIGHT  6'h2E
`define SSCE_FN_SLI       6'h00
`define SSCE_FN_SRLI      6'h02
`define SSCE_FN_SRAI      6'h03
`define SSCE_FN_SLV       6'h04
`define SSCE_FN_SHIFT_RIGHT_LOGIC_VAR      6'h06
`define SSCE_FN_SHIFT_RIGHT_ARITH_VAR      6'h07
`define SSCE_FN_DBGTRAP   6'h0E
`define SSCE_FN_SUBT      6'h22
`define SSCE_FN_SUBN      6'h23
`define SSCE_FN_LTS       6'h2A
`define SSCE_FN_LTU       6'h2B
`define SSCE_EXC_NONE     2'h0
`define SSCE_EXC_DEBUG    2'h1
`define SSCE_EXC_ADDR     2'h2
`define SSCE_EXC_OVF      2'h3
`define SSCE_SIZE_HALF    2'h1
`define SSCE_SIZE_WORD    2'h2
`define SSCE_SIZE_LEFT    2'h3
`define SSCE_SIZE_RIGHT   2'h0
`endif

// *** ssce_alu.v ***
/*
 Combinational shift, compare and subtract unit.
 Assumes operands are already read from the register file.
*/
`timescale 1ns/10ps
module ssce_alu #(
   parameter WIDTH = 32
) (
   // Operation select.
   input  wire [2:0]       opSel,
   input  wire [4:0]       shiftAmount,
   // Operands.
   input  wire [WIDTH-1:0] opA,
   input  wire [WIDTH-1:0] opB,
   // Results.
   output reg  [WIDTH-1:0] result,
   output wire             overflow
);
   wire [WIDTH-1:0] diff;
   wire             ltSigned;
   wire             ltUnsigned;

   // Sign bits decide the signed compare, so overflow of the
   // difference never corrupts the answer.
   assign diff       = opA - opB;
   assign ltSigned   = (opA[WIDTH-1] != opB[WIDTH-1]) ? opA[WIDTH-1] :
                       diff[WIDTH-1];
   assign ltUnsigned = opA < opB;
   // Carries into and out of the top bit differ exactly when the
   // operand signs differ and the result sign follows the subtrahend.
   assign overflow   = (opA[WIDTH-1] != opB[WIDTH-1]) &&
                       (diff[WIDTH-1] != opA[WIDTH-1]);

   // Result select; opB is the shifted value for shifts.
   always @* begin
      case (opSel)
         3'h0: result = opB << shiftAmount;
         3'h1: result = opB >> shiftAmount;
         3'h2: result = $signed(opB) >>> shiftAmount;
         3'h3: result = {{(WIDTH-1){1'b0}}, ltSigned};
         3'h4: result = {{(WIDTH-1){1'b0}}, ltUnsigned};
         3'h5: result = diff;
         default: result = {WIDTH{1'b0}};
      endcase
   end
endmodule // ssce_alu

// *** ssce_store_lane.v ***
/*
 Store lane placement: byte enables and data steering for halfword,
 word and partial word stores. Assumes a 32-bit memory word.
*/
`timescale 1ns/10ps
`include "ssce_map.vh"
module ssce_store_lane (
   // Request.
   input  wire [1:0]  storeSize,
   input  wire [1:0]  addrLow,
   input  wire        bigEndian,
   input  wire [31:0] regData,
   // Lane outputs.
   output reg  [3:0]  byteEnable,
   output reg  [31:0] laneData
);
   reg [1:0] lane;

   // Lane index counts from the word's low-order byte in memory; big
   // endian flips the byte numbering within the word.
   always @* begin
      lane       = bigEndian ? ~addrLow : addrLow;
      byteEnable = 4'h0;
      laneData   = 32'h0;
      case (storeSize)
         `SSCE_SIZE_HALF: begin
            byteEnable = lane[1] ? 4'hC : 4'h3;
            laneData   = {regData[15:0], regData[15:0]};
         end
         `SSCE_SIZE_WORD: begin
            byteEnable = 4'hF;
            laneData   = regData;
         end
         // top bytes downward. Register MSB lands in the
         // addressed lane, lower bytes fill lanes below it.
         `SSCE_SIZE_LEFT: begin
            byteEnable = 4'hF >> (2'h3 - lane);
            laneData   = regData >> {(2'h3 - lane), 3'h0};
         end
         // bottom bytes upward. Register LSB lands in the
         // addressed lane, higher bytes fill lanes above it.
         default: begin
            byteEnable = 4'hF << lane;
            laneData   = regData << {lane, 3'h0};
         end
      endcase
   end
endmodule // ssce_store_lane

// *** ssce_exec_properties.sv ***
/*
 Concurrent checks on the ports of the execute slice, bound to ssce_exec.
 Assumes results appear one enabled edge after the instruction is taken.
*/
`timescale 1ns/10ps
`include "ssce_map.vh"
module ssce_exec_properties (
   // Clock and control.
   input wire        clock,
   input wire        rst,
   input wire        clockEnable,
   input wire        bigEndian,
   // Instruction and operands.
   input wire        instrValid,
   input wire [31:0] instrWord,
   input wire [31:0] sourceValue,
   input wire [31:0] targetValue,
   // Results.
   input wire        wbEnable,
   input wire [4:0]  wbIndex,
   input wire [31:0] wbData,
   input wire        storeValid,
   input wire [31:0] storeAddr,
   input wire [3:0]  storeByteEnable,
   input wire [31:0] storeData,
   input wire        excValid,
   input wire [1:0]  excCode,
   input wire [31:0] excBadAddr
);
   // Reference values formed from the inputs of the taking edge.
   wire        taken = instrValid && clockEnable;
   wire [5:0]  op = instrWord[31:26];
   wire [5:0]  fn = instrWord[5:0];
   wire        spec = taken && op == `SSCE_OP_SPECIAL;
   wire [31:0] diffVal = sourceValue - targetValue;
   wire        subOvf = (sourceValue[31] != targetValue[31]) &&
                        (diffVal[31] != sourceValue[31]);
   wire        ltSigned = $signed(sourceValue) < $signed(targetValue);
   wire [31:0] sllVal = targetValue << instrWord[10:6];
   wire [31:0] effAddr = sourceValue + {{16{instrWord[15]}}, instrWord[15:0]};
   wire [31:0] wordAddr = {effAddr[31:2], 2'h0};
   wire [3:0]  halfBe = (effAddr[1] ^ bigEndian) ? 4'hC : 4'h3;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   exc_alone_a: assert property (excValid |->
      !wbEnable && !storeValid)
      else $error("exception came with a write or store");
   st_align_a: assert property (storeValid |->
      storeAddr[1:0] == 2'h0)
      else $error("store address not word aligned");
   be_idle_a: assert property (!storeValid |->
      storeByteEnable == 4'h0)
      else $error("byte enables set without a store");
   trap_take_a: assert property (spec && fn == `SSCE_FN_DBGTRAP
      |=> excValid && excCode == `SSCE_EXC_DEBUG) else $error("no debug trap");
   sub_ovf_a: assert property (spec && fn == `SSCE_FN_SUBT
      && subOvf |=> excValid && excCode == `SSCE_EXC_OVF)
      else $error("no overflow");
   subtract_nontrapping_wb_a: assert property (spec && fn == `SSCE_FN_SUBN
      |=> wbEnable && !excValid && wbData == $past(diffVal))
      else $error("non-trapping subtract wrong");
   lts_val_a: assert property (spec && fn == `SSCE_FN_LTS
      |=> wbEnable && !excValid && wbData == {31'h0, $past(ltSigned)})
      else $error("signed compare wrong");
   sll_val_a: assert property (spec && fn == `SSCE_FN_SLI
      |=> wbEnable && wbData == $past(sllVal)) else $error("left shift wrong");
   half_odd_a: assert property (taken && op == `SSCE_OP_STHALF
      && effAddr[0] |=> excValid && excCode == `SSCE_EXC_ADDR)
      else $error("odd half stored");
   half_lane_a: assert property (taken && op == `SSCE_OP_STHALF
      && !effAddr[0] |=> storeValid && storeAddr == $past(wordAddr) &&
      storeByteEnable == $past(halfBe)) else $error("half store lanes wrong");
   word_full_a: assert property (taken && op == `SSCE_OP_STWORD &&
      effAddr[1:0] == 2'h0 && !bigEndian |=> storeValid &&
      storeByteEnable == 4'hF && storeData == $past(targetValue))
      else $error("word store wrong");
   swl_ok_a: assert property (taken && op == `SSCE_OP_STPLEFT
      |=> storeValid && !excValid) else $error("left partial store refused");
   hold_freeze_a: assert property (!clockEnable |=> $stable(wbEnable) &&
      $stable(storeValid) && $stable(excValid))
      else $error("moved while frozen");
endmodule // ssce_exec_properties
bind ssce_exec ssce_exec_properties u_props (.clock(clock), .rst(rst),
   .clockEnable(clockEnable), .bigEndian(bigEndian), .instrValid(instrValid),
   .instrWord(instrWord), .sourceValue(sourceValue),
   .targetValue(targetValue), .wbEnable(wbEnable), .wbIndex(wbIndex),
   .wbData(wbData), .storeValid(storeValid), .storeAddr(storeAddr),
   .storeByteEnable(storeByteEnable), .storeData(storeData),
   .excValid(excValid), .excCode(excCode), .excBadAddr(excBadAddr));

// *** ssce_mem_model.sv ***
/*
 Data memory model behind the store port: sixteen words written lane by
 lane. Assumes each store arrives as a one-cycle pulse.
*/
`timescale 1ns/10ps
module ssce_mem_model (
   // Clock and reset.
   input  wire        clock,
   input  wire        rst,
   // Store port.
   input  wire        storeValid,
   input  wire [31:0] storeAddr,
   input  wire [3:0]  storeByteEnable,
   input  wire [31:0] storeData,
   // Inspection port.
   input  wire [3:0]  peekAddr,
   output wire [31:0] peekData
);
   reg [31:0] mem [0:15];
   integer    k;
   assign peekData = mem[peekAddr];
   // Only enabled lanes change, so a stray enable shows up as damage.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (k = 0; k < 16; k = k + 1) mem[k] <= 32'h11223344;
      end else if (storeValid) begin
         for (k = 0; k < 4; k = k + 1) begin
            if (storeByteEnable[k])
               mem[storeAddr[5:2]][8*k +: 8] <= storeData[8*k +: 8];
         end
      end
   end
endmodule // ssce_mem_model

// *** store_shift_compare_exec_test.sv ***
/*
 Self-checking bench for the execute slice and its store memory model.
 Assumes the slice answers exactly one cycle after the taking edge.
*/
`timescale 1ns/10ps
`include "ssce_map.vh"
module store_shift_compare_exec_test;
   reg         clock, rst, clockEnable, bigEndian, instrValid;
   reg  [31:0] instrWord, sourceValue, targetValue;
   reg  [3:0]  peekAddr;
   wire        wbEnable, storeValid, excValid;
   wire [4:0]  wbIndex;
   wire [31:0] wbData, storeAddr, storeData, excBadAddr, peekData;
   wire [3:0]  storeByteEnable;
   wire [1:0]  excCode;
   integer     errors, n_checks, i;
   ssce_exec DUT (.clock(clock), .rst(rst), .clockEnable(clockEnable),
      .bigEndian(bigEndian), .instrValid(instrValid), .instrWord(instrWord),
      .sourceValue(sourceValue), .targetValue(targetValue),
      .wbEnable(wbEnable), .wbIndex(wbIndex), .wbData(wbData),
      .storeValid(storeValid), .storeAddr(storeAddr),
      .storeByteEnable(storeByteEnable), .storeData(storeData),
      .excValid(excValid), .excCode(excCode), .excBadAddr(excBadAddr));
   ssce_mem_model u_mem (.clock(clock), .rst(rst), .storeValid(storeValid),
      .storeAddr(storeAddr), .storeByteEnable(storeByteEnable),
      .storeData(storeData), .peekAddr(peekAddr), .peekData(peekData));
   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Instruction encoders; register forms write rd 3, immediates rt 4.
   function [31:0] rfm(input [5:0] f, input [4:0] sa);
      rfm = {`SSCE_OP_SPECIAL, 5'h01, 5'h02, 5'h03, sa, f};
   endfunction
   function [31:0] ifm(input [5:0] o, input [15:0] imm);
      ifm = {o, 5'h01, 5'h04, imm};
   endfunction
   task cmpv(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Drives one instruction for one edge; returns with its answer standing.
   task run(input [31:0] w, input [31:0] s, input [31:0] t);
      begin
         @(negedge clock);
         instrWord = w;
         sourceValue = s;
         targetValue = t;
         instrValid = 1'b1;
         @(negedge clock);
         instrValid = 1'b0;
      end
   endtask
   // Flags are write, store, exception; data and code judged when raised.
   task want(input [2:0] f, input [31:0] d, input [1:0] c);
      begin
         cmpv({29'h0, wbEnable, storeValid, excValid}, {29'h0, f});
         if (f[2]) cmpv(wbData, d);
         if (f[0]) cmpv({30'h0, excCode}, {30'h0, c});
      end
   endtask
   task stchk(input [31:0] a, input [3:0] be, input [31:0] d);
      begin
         cmpv(storeAddr, a);
         cmpv({28'h0, storeByteEnable}, {28'h0, be});
         cmpv(storeData, d);
      end
   endtask
   // Sign bit set in the operand and upper count bits set in the source.
   task t_shift;
      reg [31:0] v;
      reg [4:0]  n;
      begin
         v = 32'h800000F1;
         for (i = 0; i < 2; i = i + 1) begin
            n = i ? 5'h1F : 5'h04;
            run(rfm(`SSCE_FN_SLI, n), 32'h0, v);
            want(3'h4, v << n, 2'h0);
            run(rfm(`SSCE_FN_SLV, 5'h00), {27'h7FFFFFF, n}, v);
            want(3'h4, v << n, 2'h0);
            run(rfm(`SSCE_FN_SRLI, n), 32'h0, v);
            want(3'h4, v >> n, 2'h0);
            run(rfm(`SSCE_FN_SHIFT_RIGHT_LOGIC_VAR, 5'h00), {27'h7FFFFFF, n}, v);
            want(3'h4, v >> n, 2'h0);
            run(rfm(`SSCE_FN_SRAI, n), 32'h0, v);
            want(3'h4, $signed(v) >>> n, 2'h0);
            run(rfm(`SSCE_FN_SHIFT_RIGHT_ARITH_VAR, 5'h00), {27'h7FFFFFF, n}, v);
            want(3'h4, $signed(v) >>> n, 2'h0);
         end
         cmpv({27'h0, wbIndex}, 32'h3);
         $display("t_shift done");
      end
   endtask
   // Operands whose difference overflows, and an all-ones immediate.
   task t_cmp;
      begin
         run(rfm(`SSCE_FN_LTS, 5'h00), 32'h80000000, 32'h7FFFFFFF);
         want(3'h4, 32'h1, 2'h0);
         run(rfm(`SSCE_FN_LTU, 5'h00), 32'h80000000, 32'h7FFFFFFF);
         want(3'h4, 32'h0, 2'h0);
         run(ifm(`SSCE_OP_LTSI, 16'h8000), 32'h7FFFFFFF, 32'h0);
         want(3'h4, 32'h0, 2'h0);
         run(ifm(`SSCE_OP_LTSI, 16'hFFFF), 32'hFFFFFFFE, 32'h0);
         want(3'h4, 32'h1, 2'h0);
         run(ifm(`SSCE_OP_LTUI, 16'hFFFF), 32'hFFFFFFFE, 32'h0);
         want(3'h4, 32'h1, 2'h0);
         cmpv({27'h0, wbIndex}, 32'h4);
         $display("t_cmp done");
      end
   endtask
   task t_sub;
      begin
         run(rfm(`SSCE_FN_SUBT, 5'h00), 32'h80000000, 32'h1);
         want(3'h1, 32'h0, `SSCE_EXC_OVF);
         run(rfm(`SSCE_FN_SUBT, 5'h00), 32'h5, 32'h7);
         want(3'h4, 32'hFFFFFFFE, 2'h0);
         run(rfm(`SSCE_FN_SUBN, 5'h00), 32'h80000000, 32'h1);
         want(3'h4, 32'h7FFFFFFF, 2'h0);
         $display("t_sub done");
      end
   endtask
   // Base 0x44 with negative offsets, +1 for right partial stores; memory words start as 11223344.
   task t_store;
      begin
         run(ifm(`SSCE_OP_STWORD, 16'hFFFC), 32'h44, 32'hA1B2C3D4);
         want(3'h2, 32'h0, 2'h0);
         stchk(32'h40, 4'hF, 32'hA1B2C3D4);
         run(ifm(`SSCE_OP_STWORD, 16'hFFFE), 32'h44, 32'hA1B2C3D4);
         want(3'h1, 32'h0, `SSCE_EXC_ADDR);
         cmpv(excBadAddr, 32'h42);
         run(ifm(`SSCE_OP_STHALF, 16'hFFFE), 32'h44, 32'hA1B2C3D4);
         want(3'h2, 32'h0, 2'h0);
         stchk(32'h40, 4'hC, 32'hC3D4C3D4);
         run(ifm(`SSCE_OP_STHALF, 16'hFFFF), 32'h44, 32'hA1B2C3D4);
         want(3'h1, 32'h0, `SSCE_EXC_ADDR);
         run(ifm(`SSCE_OP_STPLEFT, 16'hFFFD), 32'h44, 32'hA1B2C3D4);
         want(3'h2, 32'h0, 2'h0);
         stchk(32'h40, 4'h3, 32'h0000A1B2);
         run(ifm(`SSCE_OP_STPRIGHT, 16'h0001), 32'h44, 32'hA1B2C3D4);
         stchk(32'h44, 4'hE, 32'hB2C3D400);
         @(negedge clock);
         cmpv(peekData, 32'hC3D4A1B2);
         peekAddr = 4'h1;
         #1 cmpv(peekData, 32'hB2C3D444);
         // Big endian mirrors the lane within the word; data is not swapped.
         @(negedge clock);
         bigEndian = 1'b1;
         run(ifm(`SSCE_OP_STPLEFT, 16'hFFFD), 32'h44, 32'hA1B2C3D4);
         stchk(32'h40, 4'h7, 32'h00A1B2C3);
         run(ifm(`SSCE_OP_STPRIGHT, 16'h0001), 32'h44, 32'hA1B2C3D4);
         stchk(32'h44, 4'hC, 32'hC3D40000);
         run(ifm(`SSCE_OP_STHALF, 16'hFFFC), 32'h44, 32'hA1B2C3D4);
         stchk(32'h40, 4'hC, 32'hC3D4C3D4);
         bigEndian = 1'b0;
         $display("t_store done");
      end
   endtask
   // Trap with a full code field, a frozen stage, then an unknown opcode.
   task t_trap;
      begin
         run({`SSCE_OP_SPECIAL, 20'hFFFFF, `SSCE_FN_DBGTRAP}, 32'h0, 32'h0);
         want(3'h1, 32'h0, `SSCE_EXC_DEBUG);
         clockEnable = 1'b0;
         @(negedge clock);
         cmpv({31'h0, excValid}, 32'h1);
         clockEnable = 1'b1;
         run({6'h3F, 26'h0}, 32'h0, 32'h0);
         want(3'h0, 32'h0, 2'h0);
         $display("t_trap done");
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", n_checks, errors);
         if (errors == 0 && n_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // Cuts a hang short.
   initial begin
      #200000;
      errors = errors + 1;
      results;
   end
   // Main sequence.
   initial begin
      errors = 0;
      n_checks = 0;
      rst = 1'b1;
      clockEnable = 1'b1;
      bigEndian = 1'b0;
      instrValid = 1'b0;
      instrWord = 32'h0;
      sourceValue = 32'h0;
      targetValue = 32'h0;
      peekAddr = 4'h0;
      repeat (8) @(negedge clock);
      rst = 1'b0;
      t_shift;
      t_cmp;
      t_sub;
      t_store;
      t_trap;
      results;
   end
endmodule // store_shift_compare_exec_test
